/* pkg/xfer_pkg.sv */
// Purpose: constants and operation codes for the register-transfer executor
// Assumes: one instruction per clock, decoded upstream into an op code
// Notes: op codes are a local encoding, not instruction bit patterns
package xfer_pkg;
  localparam int NIBBLE_W = 4;
  localparam int EXT_W = 8;
  localparam int PAGE_W = 3;
  localparam int BANK_W = 2;
  localparam int SP_W = 3;
  localparam int OP_W = 4;
  localparam logic [3:0] WORD_WRAP_UP = 4'h0;
  localparam logic [3:0] WORD_WRAP_DOWN = 4'hF;
  localparam logic [3:0] RST_NIBBLE = 4'h0;
  localparam logic [7:0] RST_EXT = 8'h00;
  localparam logic [2:0] RST_PAGE = 3'h0;
  localparam logic [1:0] RST_BANK = 2'h0;

  typedef enum logic [3:0] {
    OP_NOP = 4'h0,
    OP_EXT_SPLIT = 4'h1,
    OP_ACC_TO_PAGE = 4'h2,
    OP_PAGE_TO_ACC = 4'h3,
    OP_BANK_TO_ACC = 4'h4,
    OP_FILE_TO_ACC = 4'h5,
    OP_SP_TO_ACC = 4'h6,
    OP_LOAD_PTR = 4'h7,
    OP_LOAD_BANK = 4'h8,
    OP_INC_WORD = 4'h9,
    OP_DEC_WORD = 4'hA,
    OP_MEM_TO_ACC = 4'hB,
    OP_SWAP = 4'hC,
    OP_SWAP_DEC = 4'hD,
    OP_SWAP_INC = 4'hE,
    OP_ACC_TO_MEM = 4'hF
  } op_t;
endpackage

/* logic/ram_addr_reg_transfer_exec.sv */
// Purpose: execute register-transfer and ram-pointer instructions of a 4-bit cpu
// Assumes: ram is external, combinational read, written on the clock edge
// Notes: one instruction taken per clock when instr_valid_in is high
`timescale 1ns/10ps

// Contract
// - extension high to aux, low to accumulator
// - accumulator low three bits load page
// - page into accumulator low three bits
// - bank select into accumulator low two bits
// - file select copied into accumulator
// - stack pointer into accumulator low three bits
// - load pointer sets file and word select
// - consecutive load pointers after first are skipped
// - load bank sets bank select from immediate
// - increment word, skip next on wrap zero
// - decrement word, skip next on fifteen
// - memory to accumulator, then file xor immediate
// - swap memory and accumulator, then file xor
// - swap, xor, decrement word, skip on fifteen
// - swap, xor, increment word, skip on zero
// - accumulator to memory, then file xor
module ram_addr_reg_transfer_exec
  import xfer_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic instr_valid_in,
  input wire logic [OP_W-1:0] op_in,
  input wire logic [NIBBLE_W-1:0] imm_hi_in,
  input wire logic [NIBBLE_W-1:0] imm_lo_in,
  input wire logic [EXT_W-1:0] ext_in,
  input wire logic [SP_W-1:0] stack_pointer_in,
  input wire logic [NIBBLE_W-1:0] ram_rdata_in,
  output logic [NIBBLE_W-1:0] acc_out,
  output logic [NIBBLE_W-1:0] aux_out,
  output logic [PAGE_W-1:0] page_out,
  output logic [BANK_W-1:0] bank_select_out,
  output logic [NIBBLE_W-1:0] file_select_out,
  output logic [NIBBLE_W-1:0] word_select_out,
  output logic ram_we_out,
  output logic [NIBBLE_W-1:0] ram_wdata_out,
  output logic skip_out
);

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  logic [NIBBLE_W-1:0] acc;
  logic [NIBBLE_W-1:0] aux;
  logic [PAGE_W-1:0] page;
  logic [BANK_W-1:0] bank;
  logic [NIBBLE_W-1:0] file_sel;
  logic [NIBBLE_W-1:0] word_sel;
  logic skip;
  logic last_was_ptr;

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------
  // one step of the word pointer; wraps both ways
  function automatic logic [NIBBLE_W-1:0] word_step(
    input logic [NIBBLE_W-1:0] value,
    input logic up
  );
    logic [NIBBLE_W-1:0] result;
    if (up) begin
      result = value + 4'h1;
    end else begin
      result = value - 4'h1;
    end
    return result;
  endfunction

  // skip condition on the stepped pointer
  function automatic logic word_skip(
    input logic [NIBBLE_W-1:0] value,
    input logic up
  );
    logic hit;
    if (up) begin
      hit = value == WORD_WRAP_UP;
    end else begin
      hit = value == WORD_WRAP_DOWN;
    end
    return hit;
  endfunction

  // narrow field into the low accumulator bits, top bits kept
  function automatic logic [NIBBLE_W-1:0] merge_page(
    input logic [NIBBLE_W-1:0] old_acc,
    input logic [PAGE_W-1:0] field
  );
    return {old_acc[NIBBLE_W-1:PAGE_W], field};
  endfunction

  function automatic logic [NIBBLE_W-1:0] merge_bank(
    input logic [NIBBLE_W-1:0] old_acc,
    input logic [BANK_W-1:0] field
  );
    return {old_acc[NIBBLE_W-1:BANK_W], field};
  endfunction

  // ops that exchange accumulator and pointed ram word
  function automatic logic swap_op(input op_t code);
    return code == OP_SWAP || code == OP_SWAP_DEC || code == OP_SWAP_INC;
  endfunction

  // ops that touch the pointed ram word, all followed by the file xor
  function automatic logic mem_op(input op_t code);
    return swap_op(code) || code == OP_MEM_TO_ACC || code == OP_ACC_TO_MEM;
  endfunction

  // ops that write the pointed ram word
  function automatic logic store_op(input op_t code);
    return swap_op(code) || code == OP_ACC_TO_MEM;
  endfunction

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  op_t op;
  assign op = op_t'(op_in);

  // a skipped slot is fetched but has no effect except on pointer chaining; no ram write in reset
  wire live = instr_valid_in && !skip && !rst_in;
  wire ptr_chain = op == OP_LOAD_PTR && last_was_ptr;
  wire exec = live && !ptr_chain;
  wire is_swap = swap_op(op);
  wire is_mem = mem_op(op);
  wire is_store = store_op(op);
  wire do_inc = op == OP_INC_WORD || op == OP_SWAP_INC;
  wire do_dec = op == OP_DEC_WORD || op == OP_SWAP_DEC;
  wire do_step = do_inc || do_dec;
  wire [NIBBLE_W-1:0] word_next_step = word_step(word_sel, do_inc);
  wire step_skip = word_skip(word_next_step, do_inc);

  // one strobe per instruction or instruction group, all qualified by exec
  wire run_ext_split = exec && op == OP_EXT_SPLIT;
  wire run_acc_to_page = exec && op == OP_ACC_TO_PAGE;
  wire run_page_to_acc = exec && op == OP_PAGE_TO_ACC;
  wire run_bank_to_acc = exec && op == OP_BANK_TO_ACC;
  wire run_file_to_acc = exec && op == OP_FILE_TO_ACC;
  wire run_sp_to_acc = exec && op == OP_SP_TO_ACC;
  wire run_load_ptr = exec && op == OP_LOAD_PTR;
  wire run_load_bank = exec && op == OP_LOAD_BANK;
  wire run_mem_load = exec && op == OP_MEM_TO_ACC;
  wire run_swap = exec && is_swap;
  wire run_mem = exec && is_mem;
  wire run_step = exec && do_step;

  // ----------------------------------------------------------------
  // accumulator
  // ----------------------------------------------------------------
  logic [NIBBLE_W-1:0] next_acc;
  always_comb begin
    next_acc = acc;
    if (run_ext_split) begin
      next_acc = ext_in[NIBBLE_W-1:0];
    end else if (run_page_to_acc) begin
      next_acc = merge_page(acc, page);
    end else if (run_bank_to_acc) begin
      next_acc = merge_bank(acc, bank);
    end else if (run_file_to_acc) begin
      next_acc = file_sel;
    end else if (run_sp_to_acc) begin
      next_acc = merge_page(acc, stack_pointer_in);
    end else if (run_mem_load) begin
      next_acc = ram_rdata_in;
    end else if (run_swap) begin
      next_acc = ram_rdata_in;
    end
  end

  // ----------------------------------------------------------------
  // auxiliary register
  // ----------------------------------------------------------------
  logic [NIBBLE_W-1:0] next_aux;
  always_comb begin
    next_aux = aux;
    if (run_ext_split) begin
      next_aux = ext_in[EXT_W-1:NIBBLE_W];
    end
  end

  // ----------------------------------------------------------------
  // page register
  // ----------------------------------------------------------------
  logic [PAGE_W-1:0] next_page;
  always_comb begin
    next_page = page;
    if (run_acc_to_page) begin
      next_page = acc[PAGE_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // bank select
  // ----------------------------------------------------------------
  logic [BANK_W-1:0] next_bank;
  always_comb begin
    next_bank = bank;
    if (run_load_bank) begin
      next_bank = imm_lo_in[BANK_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // file select
  // ----------------------------------------------------------------
  logic [NIBBLE_W-1:0] next_file;
  always_comb begin
    next_file = file_sel;
    if (run_load_ptr) begin
      next_file = imm_hi_in;
    end else if (run_mem) begin
      // xor after the access; the ram address still uses the old file
      next_file = file_sel ^ imm_lo_in;
    end
  end

  // ----------------------------------------------------------------
  // word select
  // ----------------------------------------------------------------
  logic [NIBBLE_W-1:0] next_word;
  always_comb begin
    next_word = word_sel;
    if (run_load_ptr) begin
      next_word = imm_lo_in;
    end else if (run_step) begin
      next_word = word_next_step;
    end
  end

  // ----------------------------------------------------------------
  // skip flag
  // ----------------------------------------------------------------
  logic next_skip;
  always_comb begin
    next_skip = run_step && step_skip;
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      acc <= RST_NIBBLE;
      aux <= RST_NIBBLE;
    end else begin
      acc <= next_acc;
      aux <= next_aux;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      page <= RST_PAGE;
    end else begin
      page <= next_page;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      bank <= RST_BANK;
    end else begin
      bank <= next_bank;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      file_sel <= RST_NIBBLE;
    end else begin
      file_sel <= next_file;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      word_sel <= RST_NIBBLE;
    end else begin
      word_sel <= next_word;
    end
  end

  // a consumed slot clears the skip; a skipped pointer load still chains
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      skip <= 1'b0;
      last_was_ptr <= 1'b0;
    end else if (instr_valid_in) begin
      skip <= next_skip;
      last_was_ptr <= op == OP_LOAD_PTR;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign acc_out = acc;
  assign aux_out = aux;
  assign page_out = page;
  assign bank_select_out = bank;
  assign file_select_out = file_sel;
  assign word_select_out = word_sel;
  assign skip_out = skip;
  // swap and store write the old accumulator to the pointed word
  assign ram_we_out = exec && is_store;
  assign ram_wdata_out = acc;
endmodule

/* bench/ram_addr_reg_transfer_exec_assertions.sv */
// Purpose: port-level checks of the transfer executor
// Assumes: ports as declared by the design top
// Notes: bound from the bench top file
`timescale 1ns/10ps
module ram_addr_reg_transfer_exec_assertions
  import xfer_pkg::*;
(
  input wire logic sys_clk_in, rst_in, instr_valid_in, ram_we_out, skip_out,
  input wire logic [3:0] op_in, imm_hi_in, imm_lo_in, ram_rdata_in, acc_out, aux_out,
  input wire logic [3:0] file_select_out, word_select_out, ram_wdata_out,
  input wire logic [7:0] ext_in
);
  logic lp_prev;
  wire g = instr_valid_in && !skip_out && !rst_in;
  always_ff @(posedge sys_clk_in) lp_prev <= !rst_in && (instr_valid_in ? op_in == OP_LOAD_PTR : lp_prev);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  sequence seq_idle_after; !skip_out && $stable(acc_out) && $stable(file_select_out); endsequence
  chk_ext_split: assert property (g && op_in == OP_EXT_SPLIT |=>
    {aux_out, acc_out} == $past(ext_in)) else $error("ext split wrong");
  chk_file_copy: assert property (g && op_in == OP_FILE_TO_ACC |=>
    acc_out == $past(file_select_out)) else $error("file copy wrong");
  chk_inc_skip: assert property (g && op_in == OP_INC_WORD |=>
    word_select_out == $past(word_select_out) + 4'h1 && skip_out == (word_select_out == WORD_WRAP_UP))
    else $error("inc word wrong");
  chk_dec_skip: assert property (g && op_in == OP_DEC_WORD |=>
    word_select_out == $past(word_select_out) - 4'h1 && skip_out == (word_select_out == WORD_WRAP_DOWN))
    else $error("dec word wrong");
  chk_load_xor: assert property (g && op_in == OP_MEM_TO_ACC |=>
    acc_out == $past(ram_rdata_in) && file_select_out == $past(file_select_out ^ imm_lo_in))
    else $error("load xor wrong");
  chk_store_write: assert property (g && op_in == OP_ACC_TO_MEM |->
    ram_we_out && ram_wdata_out == acc_out) else $error("store write wrong");
  chk_skip_idle: assert property (instr_valid_in && skip_out |->
    !ram_we_out ##1 seq_idle_after) else $error("skipped slot acted");
  chk_chain_ignored: assert property (!rst_in && lp_prev && instr_valid_in && op_in == OP_LOAD_PTR |=>
    $stable(file_select_out) && $stable(word_select_out)) else $error("chained pointer load");
endmodule

/* bench/ram_addr_reg_transfer_exec_bench.sv */
// Purpose: random self-checking bench with a reference model
// Assumes: ram read data random each cycle
// Notes: model steps on the same edge as the design
`timescale 1ns/10ps
module ram_addr_reg_transfer_exec_bench;
  import xfer_pkg::*;
  logic sys_clk_in = 0, rst_in = 1, instr_valid_in = 0, ram_we_out, skip_out, sk = 0, lp = 0, t;
  logic [3:0] op_in = 0, imm_hi_in = 0, imm_lo_in = 0, ram_rdata_in = 0, a = 0, b = 0, x = 0, y = 0;
  logic [3:0] acc_out, aux_out, file_select_out, word_select_out, ram_wdata_out;
  logic [7:0] ext_in = 0;
  logic [2:0] stack_pointer_in = 0, page_out, d = 0;
  logic [1:0] bank_select_out, z = 0;
  integer seed = 32'heff0, n_errors = 0, n_checks = 0, cyc = 0;
  ram_addr_reg_transfer_exec i_ram_addr_reg_transfer_exec (.*);
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial forever #12.5 sys_clk_in = ~sys_clk_in;
  // model and random drive
  always @(posedge sys_clk_in) begin
    cyc <= cyc + 1;
    if (rst_in) {a, b, d, z, x, y, sk, lp} = '0;
    else if (instr_valid_in) begin
      t = !sk && !(op_in == OP_LOAD_PTR && lp);
      lp = op_in == OP_LOAD_PTR;
      if (sk) sk = 0;
      else if (t) begin
        if (op_in >= OP_MEM_TO_ACC && op_in != OP_ACC_TO_MEM) a = ram_rdata_in;
        if (op_in >= OP_MEM_TO_ACC) x = x ^ imm_lo_in;
        case (op_in)
          OP_EXT_SPLIT: {b, a} = ext_in;
          OP_ACC_TO_PAGE: d = a[2:0];
          OP_PAGE_TO_ACC: a[2:0] = d;
          OP_BANK_TO_ACC: a[1:0] = z;
          OP_FILE_TO_ACC: a = x;
          OP_SP_TO_ACC: a[2:0] = stack_pointer_in;
          OP_LOAD_PTR: {x, y} = {imm_hi_in, imm_lo_in};
          OP_LOAD_BANK: z = imm_lo_in[1:0];
          OP_INC_WORD, OP_SWAP_INC: begin y = y + 4'h1; sk = y == 4'h0; end
          OP_DEC_WORD, OP_SWAP_DEC: begin y = y - 4'h1; sk = y == 4'hF; end
          default: ;
        endcase
      end
    end
    instr_valid_in <= ($random(seed) & 3) != 0;
    {op_in, imm_hi_in, imm_lo_in, ext_in, ram_rdata_in, stack_pointer_in} <= 27'($random(seed));
  end
  always @(negedge sys_clk_in) if (!rst_in) begin
    chk(acc_out, a);
    chk(aux_out, b);
    chk({1'b0, page_out}, {1'b0, d});
    chk({2'h0, bank_select_out}, {2'h0, z});
    chk(file_select_out, x);
    chk(word_select_out, y);
    chk({3'h0, skip_out}, {3'h0, sk});
    chk({3'h0, ram_we_out}, {3'h0, instr_valid_in && !sk && op_in >= OP_SWAP});
    if (ram_we_out === 1'b1) chk(ram_wdata_out, a);
  end
  initial begin
    wait (cyc == 5000);
    n_errors++;
    conclude;
  end
  initial begin
    repeat (16) @(posedge sys_clk_in);
    rst_in <= 0;
    repeat (3000) @(posedge sys_clk_in);
    $display("random transfer test done");
    conclude;
  end
endmodule
bind ram_addr_reg_transfer_exec ram_addr_reg_transfer_exec_assertions i_chk (.*);
